// ===== logic/adc_ctrl.sv
// converter control top: register slave, pin roles, result, interrupt
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"

module adc_ctrl
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // pins and analog front end
    input  wire logic [7:0]  pin_in,
    input  wire logic        cmp_in,
    output logic [2:0]       channel_select,
    output logic             hold_capacitor,
    output logic [9:0]       dac_code,
    output logic [7:0]       analog_channels,
    output logic             vref_pos_ext,
    output logic             vref_neg_ext,
    // interrupt
    output logic             irq
);
    top_s        q;
    top_s        d;
    logic        wr_fire;
    logic        wr_en;
    logic [7:0]  wb;
    logic [15:0] just_res;

    sar_if sif ();

    sar_engine u_engine (
        .aclk    (aclk),
        .aresetn (aresetn),
        .e       (sif.engine)
    );

    assign sif.on      = q.on;
    assign sif.go      = q.go;
    assign sif.clk_sel = q.clk_sel;
    assign sif.cmp     = q.cmp_s2;

    // ============================================================
    // pin configuration decode
    function automatic pin_role_s pin_decode(input logic [3:0] cfg);
        pin_role_s r;
        r = '{analog: 8'h00, vref_pos: 1'b0, vref_neg: 1'b0};
        unique casez (cfg)
            4'b0000: r.analog = 8'hFF;
            4'b0001: r = '{analog: 8'hF7, vref_pos: 1'b1, vref_neg: 1'b0};
            4'b0010: r.analog = 8'h1F;
            4'b0011: r = '{analog: 8'h17, vref_pos: 1'b1, vref_neg: 1'b0};
            4'b0100: r.analog = 8'h0B;
            4'b0101: r = '{analog: 8'h03, vref_pos: 1'b1, vref_neg: 1'b0};
            4'b011?: r.analog = 8'h00;
            4'b1000: r = '{analog: 8'hF3, vref_pos: 1'b1, vref_neg: 1'b1};
            4'b1001: r.analog = 8'h3F;
            4'b1010: r = '{analog: 8'h37, vref_pos: 1'b1, vref_neg: 1'b0};
            4'b1011: r = '{analog: 8'h33, vref_pos: 1'b1, vref_neg: 1'b1};
            4'b1100: r = '{analog: 8'h13, vref_pos: 1'b1, vref_neg: 1'b1};
            default: r.analog = 8'h00;
        endcase
        return r;
    endfunction

    // ============================================================
    // result placement
    always_comb
    begin
        if (q.justify)
            just_res = {6'h00, sif.result};
        else
            just_res = {sif.result, 6'h00};
    end

    assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
    assign wr_en   = wr_fire && q.wstrb0;
    assign wb      = q.wdata[7:0];

    // ============================================================
    // next state
    always_comb
    begin
        d = q;

        // input synchronisers
        d.pin_s1 = pin_in;
        d.pin_s2 = q.pin_s1;
        d.cmp_s1 = cmp_in;
        d.cmp_s2 = q.cmp_s1;

        // write address and data capture, either order
        if (awvalid && q.awready)
        begin
            d.awaddr  = awaddr;
            d.aw_have = 1'b1;
        end
        if (wvalid && q.wready)
        begin
            d.wdata  = wdata;
            d.wstrb0 = wstrb[0];
            d.w_have = 1'b1;
        end
        if (q.bvalid && bready)
            d.bvalid = 1'b0;

        // completion from the sequencer
        if (sif.done)
        begin
            d.go     = 1'b0;
            d.res_hi = just_res[15:8];
            d.res_lo = just_res[7:0];
        end

        // register writes
        if (wr_fire)
        begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = 2'b00;
            unique case (q.awaddr)
                `OFF_CONV_CONTROL_A:
                    if (wr_en)
                    begin
                        d.clk_sel = wb[`CA_CLK_LSB +: 2];
                        d.chan    = wb[`CA_CHAN_LSB +: 3];
                        d.on      = wb[`CA_ON_BIT];
                        // start only when already on; clear aborts
                        d.go = wb[`CA_GO_BIT] && q.on
                               && wb[`CA_ON_BIT];
                    end
                `OFF_CONV_CONTROL_B:
                    if (wr_en)
                    begin
                        d.justify = wb[`CB_JUSTIFY_BIT];
                        d.pcfg    = wb[`CB_PCFG_LSB +: 4];
                    end
                `OFF_RESULT_HIGH:
                    if (wr_en && !sif.done)
                        d.res_hi = wb;
                `OFF_RESULT_LOW:
                    if (wr_en && !sif.done)
                        d.res_lo = wb;
                `OFF_IRQ_STATUS:
                    if (wr_en && wb[`IRQ_CONV_BIT])
                        d.irq_flag = 1'b0;
                `OFF_IRQ_MASK:
                    if (wr_en)
                        d.irq_en = wb[`IRQ_CONV_BIT];
                `OFF_PORT_READ,
                `OFF_PIN_ROLE: ;
                default:
                    d.bresp = 2'b10;
            endcase
        end

        // hardware set wins over a same-cycle clear
        if (sif.done)
            d.irq_flag = 1'b1;

        // read channel
        if (q.rvalid && rready)
            d.rvalid = 1'b0;
        if (arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rresp  = 2'b00;
            d.rdata  = 32'h0000_0000;
            unique case (araddr)
                `OFF_CONV_CONTROL_A:
                    d.rdata[7:0] = {q.clk_sel, q.chan, q.go, 1'b0,
                                    q.on};
                `OFF_CONV_CONTROL_B:
                    d.rdata[7:0] = {q.justify, 3'h0, q.pcfg};
                `OFF_RESULT_HIGH:
                    d.rdata[7:0] = q.res_hi;
                `OFF_RESULT_LOW:
                    d.rdata[7:0] = q.res_lo;
                `OFF_IRQ_STATUS:
                    d.rdata[`IRQ_CONV_BIT] = q.irq_flag;
                `OFF_IRQ_MASK:
                    d.rdata[`IRQ_CONV_BIT] = q.irq_en;
                `OFF_PORT_READ:
                    d.rdata[7:0] = q.pin_s2 & ~q.role.analog;
                `OFF_PIN_ROLE:
                    d.rdata[9:0] = {q.role.vref_neg, q.role.vref_pos,
                                    q.role.analog};
                default:
                    d.rresp = 2'b10;
            endcase
        end

        // converter off drops a pending start
        if (!d.on)
            d.go = 1'b0;

        d.role    = pin_decode(d.pcfg);
        d.irq     = d.irq_flag && d.irq_en;
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;
    end

    // ============================================================
    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q.awaddr   <= 8'h00;
            q.aw_have  <= 1'b0;
            q.wdata    <= 32'h0000_0000;
            q.wstrb0   <= 1'b0;
            q.w_have   <= 1'b0;
            q.awready  <= 1'b1;
            q.wready   <= 1'b1;
            q.bvalid   <= 1'b0;
            q.bresp    <= 2'h0;
            q.arready  <= 1'b1;
            q.rvalid   <= 1'b0;
            q.rdata    <= 32'h0000_0000;
            q.rresp    <= 2'h0;
            q.clk_sel  <= `RST_CLK_SEL;
            q.chan     <= `RST_CHAN;
            q.go       <= 1'b0;
            q.on       <= 1'b0;
            q.justify  <= 1'b0;
            q.pcfg     <= `RST_PCFG;
            q.res_hi   <= `RST_RESULT;
            q.res_lo   <= `RST_RESULT;
            q.irq_flag <= 1'b0;
            q.irq_en   <= 1'b0;
            q.irq      <= 1'b0;
            q.pin_s1   <= 8'h00;
            q.pin_s2   <= 8'h00;
            q.cmp_s1   <= 1'b0;
            q.cmp_s2   <= 1'b0;
            q.role     <= '{analog: 8'hFF, vref_pos: 1'b0, vref_neg: 1'b0};
        end
        else
            q <= d;
    end

    // ============================================================
    // outputs
    assign awready         = q.awready;
    assign wready          = q.wready;
    assign bvalid          = q.bvalid;
    assign bresp           = q.bresp;
    assign arready         = q.arready;
    assign rvalid          = q.rvalid;
    assign rdata           = q.rdata;
    assign rresp           = q.rresp;
    assign channel_select  = q.chan;
    assign hold_capacitor  = sif.hold;
    assign dac_code        = sif.dac_code;
    assign analog_channels = q.role.analog;
    assign vref_pos_ext    = q.role.vref_pos;
    assign vref_neg_ext    = q.role.vref_neg;
    assign irq             = q.irq;
endmodule

// ===== logic/adc_ctrl_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// ============================================================
// register byte offsets
`define OFF_CONV_CONTROL_A 8'h00
`define OFF_CONV_CONTROL_B 8'h04
`define OFF_RESULT_HIGH    8'h08
`define OFF_RESULT_LOW     8'h0C
`define OFF_IRQ_STATUS     8'h10
`define OFF_IRQ_MASK       8'h14
`define OFF_PORT_READ      8'h18
`define OFF_PIN_ROLE       8'h1C

// ============================================================
// field positions
`define CA_ON_BIT      0
`define CA_GO_BIT      2
`define CA_CHAN_LSB    3
`define CA_CLK_LSB     6
`define CB_PCFG_LSB    0
`define CB_JUSTIFY_BIT 7
`define IRQ_CONV_BIT   0
`define ROLE_VPOS_BIT  8
`define ROLE_VNEG_BIT  9

// ============================================================
// reset values
`define RST_CLK_SEL  2'h0
`define RST_CHAN     3'h0
`define RST_PCFG     4'h0
`define RST_RESULT   8'h00

// ============================================================
// timing
`define CLK_PERIOD_NS 5
`define TAD_RC_NS     4000
`define TAD_DIV_A     2
`define TAD_DIV_B     8
`define TAD_DIV_C     32
`define TAD_RC_CYC    (`TAD_RC_NS / `CLK_PERIOD_NS)
`define CONV_TADS     12
`define GAP_TADS      2
`define BIT_TADS      10

`endif

// ===== logic/adc_ctrl_pkg.sv
// types shared by the converter control block
package adc_ctrl_pkg;

    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_ACQ  = 4'b0010,
        ST_CONV = 4'b0100,
        ST_GAP  = 4'b1000
    } seq_state_e;

    typedef struct packed {
        logic [7:0] analog;
        logic       vref_pos;
        logic       vref_neg;
    } pin_role_s;

    typedef struct packed {
        seq_state_e st;
        logic [9:0] tad_cnt;
        logic [3:0] phase;
        logic [9:0] sar;
        logic [9:0] result;
        logic       done;
        logic       hold;
    } eng_s;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        aw_have;
        logic [31:0] wdata;
        logic        wstrb0;
        logic        w_have;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  clk_sel;
        logic [2:0]  chan;
        logic        go;
        logic        on;
        logic        justify;
        logic [3:0]  pcfg;
        logic [7:0]  res_hi;
        logic [7:0]  res_lo;
        logic        irq_flag;
        logic        irq_en;
        logic        irq;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic        cmp_s1;
        logic        cmp_s2;
        pin_role_s   role;
    } top_s;

endpackage

// ===== logic/sar_if.sv
// signals between the register side and the conversion sequencer
`timescale 1ns/1ps
interface sar_if;
    logic       on;
    logic       go;
    logic [1:0] clk_sel;
    logic       cmp;
    logic       done;
    logic [9:0] result;
    logic       hold;
    logic [9:0] dac_code;

    modport ctrl (output on, go, clk_sel, cmp,
                  input  done, result, hold, dac_code);
    modport engine (input  on, go, clk_sel, cmp,
                    output done, result, hold, dac_code);
endinterface

// ===== logic/sar_engine.sv
// conversion sequencer: acquisition, 12 bit periods, 2 period gap
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module sar_engine
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control side
    sar_if.engine     e
);
    eng_s       q;
    eng_s       d;
    logic [9:0] tad_len;
    logic       tick;
    logic [3:0] bit_idx;

    // ============================================================
    // bit period length in clock cycles
    always_comb
    begin
        unique case (e.clk_sel)
            2'b00: tad_len = 10'(`TAD_DIV_A);
            2'b01: tad_len = 10'(`TAD_DIV_B);
            2'b10: tad_len = 10'(`TAD_DIV_C);
            2'b11: tad_len = 10'(`TAD_RC_CYC);
        endcase
    end

    // a shorter period selected mid-count ends the current period at once
    assign tick    = (q.tad_cnt >= tad_len - 10'h001);
    assign bit_idx = 4'(`BIT_TADS) - q.phase;

    // ============================================================
    // sequencer
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        if (!e.on)
        begin
            d.st      = ST_OFF;
            d.hold    = 1'b0;
            d.tad_cnt = 10'h000;
            d.phase   = 4'h0;
        end
        else
        begin
            unique case (q.st)
                ST_OFF:
                begin
                    d.st   = ST_ACQ;
                    d.hold = 1'b1;
                end
                ST_ACQ:
                begin
                    // channel and pin direction never gate a start
                    if (e.go)
                    begin
                        d.st      = ST_CONV;
                        d.hold    = 1'b0;
                        d.tad_cnt = 10'h000;
                        d.phase   = 4'h0;
                        d.sar     = 10'h000;
                    end
                end
                ST_CONV:
                begin
                    if (!e.go)
                    begin
                        d.st      = ST_GAP;
                        d.tad_cnt = 10'h000;
                        d.phase   = 4'h0;
                    end
                    else if (!tick)
                        d.tad_cnt = q.tad_cnt + 10'h001;
                    else
                    begin
                        d.tad_cnt = 10'h000;
                        d.phase   = q.phase + 4'h1;
                        if (q.phase == 4'h0)
                            d.sar = 10'h200;
                        else if (q.phase <= 4'(`BIT_TADS))
                        begin
                            // any level on the channel pin is converted
                            if (!e.cmp)
                                d.sar[bit_idx] = 1'b0;
                            if (bit_idx != 4'h0)
                                d.sar[bit_idx - 4'h1] = 1'b1;
                        end
                        if (q.phase == 4'(`CONV_TADS - 1))
                        begin
                            d.result = q.sar;
                            d.done   = 1'b1;
                            d.st     = ST_GAP;
                            d.phase  = 4'h0;
                        end
                    end
                end
                ST_GAP:
                begin
                    // hold capacitor stays off the input, never discharged
                    d.hold = 1'b0;
                    if (!tick)
                        d.tad_cnt = q.tad_cnt + 10'h001;
                    else
                    begin
                        d.tad_cnt = 10'h000;
                        d.phase   = q.phase + 4'h1;
                        if (q.phase == 4'(`GAP_TADS - 1))
                        begin
                            d.st    = ST_ACQ;
                            d.hold  = 1'b1;
                            d.phase = 4'h0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q.st      <= ST_OFF;
            q.tad_cnt <= 10'h000;
            q.phase   <= 4'h0;
            q.sar     <= 10'h000;
            q.result  <= 10'h000;
            q.done    <= 1'b0;
            q.hold    <= 1'b0;
        end
        else
            q <= d;
    end

    assign e.done     = q.done;
    assign e.result   = q.result;
    assign e.hold     = q.hold;
    assign e.dac_code = q.sar;
endmodule

// ===== bench/fe_model.sv
// analog front end model: comparator seen by the converter
`timescale 1ns/1ps
module fe_model (
    // converter side
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] vin,
    // comparator
    output logic            cmp_in
);
    // whatever level sits on the pin is converted
    assign cmp_in = (vin >= dac_code);
endmodule

// ===== bench/adc_ctrl_monitor.sv
// bus and sequencing checks on the converter control top
`timescale 1ns/1ps
module adc_ctrl_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // converter
    input wire logic        hold_capacitor,
    input wire logic [7:0]  analog_channels,
    input wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    // ========
    // sequences
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_gap;
        !hold_capacitor [*4];
    endsequence
    // ========
    // properties
    property p_wr_ans;
        disable iff (!aresetn) s_wr_take |-> ##[1:2] bvalid;
    endproperty
    property p_b_stand;
        disable iff (!aresetn) bvalid && !bready |=> bvalid;
    endproperty
    property p_wr_busy;
        disable iff (!aresetn) bvalid |-> !awready && !wready;
    endproperty
    property p_r_ans;
        disable iff (!aresetn) arvalid && arready |=> rvalid;
    endproperty
    property p_r_stand;
        disable iff (!aresetn)
            rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    property p_rd_busy;
        disable iff (!aresetn) rvalid |-> !arready;
    endproperty
    property p_rst;
        !aresetn |=> !bvalid && !rvalid && !irq && !hold_capacitor
            && analog_channels == 8'hFF;
    endproperty
    property p_gap;
        disable iff (!aresetn) $fell(hold_capacitor) |-> s_gap;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write response late");
    a_b_stand: assert property (p_b_stand)
        else $error("write response dropped");
    a_wr_busy: assert property (p_wr_busy)
        else $error("write ready during response");
    a_r_ans: assert property (p_r_ans)
        else $error("read data late");
    a_r_stand: assert property (p_r_stand)
        else $error("read data dropped or changed");
    a_rd_busy: assert property (p_rd_busy)
        else $error("read ready during data");
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
    a_gap: assert property (p_gap)
        else $error("hold reconnected too soon");
endmodule

bind adc_ctrl adc_ctrl_monitor mon (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
    .rready, .rdata, .hold_capacitor, .analog_channels, .irq);

// ===== bench/tb.sv
// self-checking bench for the converter control top
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value t=%0t %h %h", $time, g, e); end end
module tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, cmp_in;
    logic        hold_capacitor, vref_pos_ext, vref_neg_ext, irq;
    logic [1:0]  bresp, rresp;
    logic [2:0]  channel_select;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr, pin_in, analog_channels;
    logic [9:0]  dac_code, vin;
    logic [31:0] wdata, rdata;
    int          n_errors, samples_checked, cyc;

    adc_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in,
        .cmp_in, .channel_select, .hold_capacitor, .dac_code,
        .analog_channels, .vref_pos_ext, .vref_neg_ext, .irq);
    fe_model fm (.dac_code, .vin, .cmp_in);

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    // ========
    // bus tasks
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail();
        n_errors++;
        give_verdict();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        int k;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 300; k++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k >= 300) fail();
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 300; k++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k >= 300) fail();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        `CHK({r, d}, {2'h0, e})
    endtask

    // ========
    // scenarios
    task automatic cfg_run();
        logic [31:0] d;
        logic [1:0]  r;
        rchk(8'h00, 32'h0);
        rchk(8'h1C, 32'hFF);
        rchk(8'h18, 32'h0);
        wr(8'h04, 32'h6);
        rchk(8'h1C, 32'h0);
        rchk(8'h18, 32'hFF);
        pin_in <= 8'hA5;
        wr(8'h04, 32'h7);
        rchk(8'h1C, 32'h0);
        wr(8'h04, 32'h8);
        rchk(8'h1C, 32'h3F3);
        `CHK(vref_pos_ext & vref_neg_ext, 1'b1)
        wr(8'h04, 32'h9);
        rchk(8'h1C, 32'h3F);
        rchk(8'h18, 32'h80);
        rd(8'h20, d, r);
        `CHK(r, 2'h2)
        wr(8'h24, 32'h1, 2'h2);
    endtask
    task automatic abort_run();
        int k, c0;
        wr(8'h08, 32'h5A);
        wr(8'h0C, 32'hA5);
        wr(8'h00, 32'h81);
        wr(8'h00, 32'h85);
        wr(8'h00, 32'h81);
        c0 = cyc;
        for (k = 0; hold_capacitor !== 1'b1 && k < 1000; k++)
            @(posedge aclk);
        if (k >= 1000) fail();
        `CHK(cyc - c0 >= 2 * 32 - 4, 1'b1)
        `CHK(cyc - c0 <= 2 * 32 + 4, 1'b1)
        rchk(8'h08, 32'h5A);
        rchk(8'h0C, 32'hA5);
        rchk(8'h10, 32'h0);
    endtask
    task automatic conv(input logic [1:0] sel, input logic [9:0] v);
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] e;
        int          k, t, c0;
        t = sel == 2'h0 ? 2 : sel == 2'h1 ? 8 : sel == 2'h2 ? 32 : 800;
        e = sel[0] ? {6'h0, v} : {v, 6'h0};
        vin <= v;
        wr(8'h04, {24'h0, sel[0], 7'h9});
        wr(8'h00, {24'h0, sel, sel[1], sel, 3'h1});
        wr(8'h14, {31'h0, sel != 2'h3});
        // acquisition time after the channel change
        repeat (3944) @(posedge aclk);
        c0 = cyc;
        wr(8'h00, {24'h0, sel, sel[1], sel, 3'h5});
        `CHK(channel_select, {sel[1], sel})
        rd(8'h00, d, r);
        `CHK(d[2], 1'b1)
        for (k = 0; d[2] === 1'b1 && k < 5000; k++)
            rd(8'h00, d, r);
        if (k >= 5000) fail();
        `CHK(cyc - c0 >= 12 * t, 1'b1)
        `CHK(cyc - c0 <= 13 * t + 20, 1'b1)
        rchk(8'h08, {24'h0, e[15:8]});
        rchk(8'h0C, {24'h0, e[7:0]});
        rchk(8'h10, 32'h1);
        `CHK(irq, sel != 2'h3)
        wr(8'h10, 32'h1);
        `CHK(irq, 1'b0)
    endtask
    task automatic reset_run();
        wr(8'h00, 32'h39);
        wr(8'h00, 32'h3D);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (40) @(posedge aclk);
        `CHK(hold_capacitor, 1'b0)
        rchk(8'h00, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h08, 32'h0);
        rchk(8'h1C, 32'hFF);
    endtask

    initial
    begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        pin_in = 8'hFF;
        vin = 10'h000;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        cfg_run();
        abort_run();
        conv(2'h0, 10'h3FF);
        conv(2'h1, 10'h000);
        conv(2'h2, 10'h2A5);
        conv(2'h3, 10'h15A);
        reset_run();
        give_verdict();
    end
endmodule
